// ### rtl/pcd_pkg.sv
// Function
// - software sets the loop multiplier anywhere from 1 to 64
// - pre-divider divides by 1 to 32, sixteen system dividers by 2 to 64 (even only), each disableable
// - a disabled divider outputs no clock, toggling only while enabled
// - after reset the mode select bit is writable but inert until source cleared
// - mode select 1 uses pre-divider and loop; 0 feeds reference straight through
// - controller comes out of reset in bypass with mode select reading 0
// - loop mode needs pre-divider enabled; reference divided, multiplied, fed on
// - each enabled system divider divides its source (loop output, or reference in bypass) by 2*(ratio+1), 50% duty
// - ratio writes leave the divider rate unchanged until a commit runs
// - writing 1 to commit set starts a commit operation
// - aligned changed clocks pause low, then restart together rising-edge aligned
// - changed clocks without align bit switch ratio immediately, no pause
// - commit in progress reads set for the whole commit, clears at the end
// - a write that changes a divider ratio sets its ratio change flag
// - mode select source is control bit 5; at 1 mode select is ignored
// - loop reset is control bit 3; 1 holds the loop in reset, 0 releases
package pcd_pkg;
  localparam int NUM_DIV = 16;
  localparam int RATIO_W = 5;
  localparam int MULT_W = 6;
  localparam int ACC_W = 7;
  localparam int CTRL_W = 8;
  // control register layout
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_LRST_BIT = 3;
  localparam int CTRL_SRC_BIT = 5;
  localparam int CTRL_ONE_BIT = 6;
  localparam logic CTRL_MODE_RST = 1'h0;
  localparam logic CTRL_LRST_RST = 1'h1;
  localparam logic CTRL_SRC_RST = 1'h1;
  localparam logic [RATIO_W-1:0] RATIO_RST = 5'h00;
  localparam logic DIV_EN_RST = 1'h1;
  // loop lock time model
  localparam int CLK_PERIOD_NS = 50;
  localparam int LOCK_TIME_NS = 1000;
  localparam int LOCK_CYCLES = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOCK_W = 8;
  typedef enum logic [0:0] {PCD_IDLE, PCD_PAUSE} pcd_commit_t;
endpackage

// ### rtl/pcd_divider.sv
`timescale 1ns/1ps
module pcd_divider (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic enable,
  input wire logic [pcd_pkg::RATIO_W-1:0] new_ratio,
  input wire logic load,
  input wire logic pause,
  input wire logic restart,
  output logic clk_out,
  output logic paused
);
  typedef struct packed {
    logic [pcd_pkg::RATIO_W-1:0] ratio;
    logic [pcd_pkg::RATIO_W-1:0] cnt;
    logic lvl;
    logic hold;
  } pcd_div_t;

  pcd_div_t st_ff;
  pcd_div_t nxt_st;

  // ----------------------------------------
  // tick is one source edge, so toggling every ratio+1 ticks is exact 50% duty
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    if (!enable) begin
      nxt_st.lvl = 1'b0;
      nxt_st.cnt = '0;
    end else if (!st_ff.hold && tick) begin
      if (st_ff.cnt >= st_ff.ratio) begin
        nxt_st.cnt = '0;
        nxt_st.lvl = ~st_ff.lvl;
      end else begin
        nxt_st.cnt = st_ff.cnt + 5'h01;
      end
    end
    if (load) begin
      nxt_st.ratio = new_ratio;
      if (nxt_st.cnt > new_ratio) begin
        nxt_st.cnt = '0;
      end
    end
    // freeze only once the clock is already low so no runt high phase appears
    if (pause && !st_ff.lvl) begin
      nxt_st.hold = 1'b1;
      nxt_st.lvl = 1'b0;
      nxt_st.cnt = st_ff.cnt;
    end
    if (restart) begin
      nxt_st.hold = 1'b0;
      nxt_st.cnt = '0;
      nxt_st.lvl = enable;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '{ratio: pcd_pkg::RATIO_RST, cnt: 5'h00, lvl: 1'b0, hold: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign clk_out = st_ff.lvl;
  assign paused = st_ff.hold;
endmodule // pcd_divider

// ### rtl/pcd_controller.sv
`timescale 1ns/1ps
module pcd_controller (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ctrl_wr,
  input wire logic [pcd_pkg::CTRL_W-1:0] ctrl_wdata,
  output logic [pcd_pkg::CTRL_W-1:0] loop_control_reg,
  input wire logic [pcd_pkg::MULT_W-1:0] multiplier_setting,
  input wire logic [pcd_pkg::RATIO_W-1:0] reference_predivider,
  input wire logic predivider_enable,
  input wire logic [pcd_pkg::NUM_DIV-1:0] div_wr,
  input wire logic [pcd_pkg::RATIO_W-1:0] div_wratio,
  input wire logic div_wen,
  input wire logic [pcd_pkg::NUM_DIV-1:0] clock_align_control,
  input wire logic commit_set,
  output logic commit_in_progress,
  output logic [pcd_pkg::NUM_DIV-1:0] ratio_change_status,
  output logic [pcd_pkg::NUM_DIV-1:0] system_divider_enable,
  output logic loop_locked,
  output logic loop_mode_active,
  output logic [pcd_pkg::NUM_DIV-1:0] system_clock_out
);
  typedef struct packed {
    logic mode;
    logic lrst;
    logic src;
    logic [pcd_pkg::NUM_DIV-1:0][pcd_pkg::RATIO_W-1:0] pend;
    logic [pcd_pkg::NUM_DIV-1:0] en;
    logic [pcd_pkg::NUM_DIV-1:0] chg;
    logic [pcd_pkg::NUM_DIV-1:0] acted;
    logic [pcd_pkg::NUM_DIV-1:0] align;
    pcd_pkg::pcd_commit_t cst;
    logic [pcd_pkg::ACC_W-1:0] acc;
    logic [pcd_pkg::LOCK_W-1:0] lock_cnt;
    logic locked;
    logic tick;
  } pcd_state_t;

  localparam logic [pcd_pkg::LOCK_W-1:0] LOCK_CNT = pcd_pkg::LOCK_W'(pcd_pkg::LOCK_CYCLES);

  pcd_state_t st_ff;
  pcd_state_t nxt_st;
  logic [pcd_pkg::NUM_DIV-1:0] paused;
  logic [pcd_pkg::NUM_DIV-1:0] load;
  logic [pcd_pkg::NUM_DIV-1:0] pause;
  logic [pcd_pkg::NUM_DIV-1:0] restart;
  logic eff_loop;
  logic all_paused;
  logic [pcd_pkg::ACC_W-1:0] mult_val;
  logic [pcd_pkg::ACC_W-1:0] pre_val;
  logic [pcd_pkg::ACC_W-1:0] acc_sum;

  // ----------------------------------------
  // mode selection and loop model
  // ----------------------------------------
  assign eff_loop = !st_ff.src && st_ff.mode;
  assign mult_val = pcd_pkg::ACC_W'(multiplier_setting) + 7'h01;
  assign pre_val = pcd_pkg::ACC_W'(reference_predivider) + 7'h01;
  assign acc_sum = st_ff.acc + mult_val;
  assign all_paused = (paused & st_ff.align) == st_ff.align;

  // ----------------------------------------
  // commit strobes towards the dividers
  // ----------------------------------------
  always_comb begin
    load = '0;
    pause = '0;
    restart = '0;
    case (st_ff.cst)
      pcd_pkg::PCD_IDLE: begin
        if (commit_set) begin
          load = st_ff.chg & ~clock_align_control;
        end
      end
      pcd_pkg::PCD_PAUSE: begin
        pause = st_ff.align;
        if (all_paused) begin
          load = st_ff.align;
          restart = st_ff.align;
        end
      end
      default: begin
        load = '0;
      end
    endcase
  end

  always_comb begin
    nxt_st = st_ff;
    if (ctrl_wr) begin
      nxt_st.mode = ctrl_wdata[pcd_pkg::CTRL_MODE_BIT];
      nxt_st.lrst = ctrl_wdata[pcd_pkg::CTRL_LRST_BIT];
      nxt_st.src = ctrl_wdata[pcd_pkg::CTRL_SRC_BIT];
    end
    // a loop output beyond the reference rate saturates at one edge per cycle
    nxt_st.tick = 1'b0;
    if (st_ff.lrst || !predivider_enable) begin
      nxt_st.acc = '0;
      nxt_st.lock_cnt = '0;
      nxt_st.locked = 1'b0;
    end else begin
      if (st_ff.lock_cnt != LOCK_CNT) begin
        nxt_st.lock_cnt = st_ff.lock_cnt + 8'h01;
      end else begin
        nxt_st.locked = 1'b1;
      end
      if (mult_val >= pre_val) begin
        nxt_st.acc = '0;
        nxt_st.tick = 1'b1;
      end else if (acc_sum >= pre_val) begin
        nxt_st.acc = acc_sum - pre_val;
        nxt_st.tick = 1'b1;
      end else begin
        nxt_st.acc = acc_sum;
      end
    end
    // unlocked output is kept off the dividers rather than glitching them
    nxt_st.tick = nxt_st.tick && nxt_st.locked;
    case (st_ff.cst)
      pcd_pkg::PCD_IDLE: begin
        if (commit_set) begin
          nxt_st.acted = st_ff.chg;
          nxt_st.align = st_ff.chg & clock_align_control;
          nxt_st.cst = pcd_pkg::PCD_PAUSE;
        end
      end
      pcd_pkg::PCD_PAUSE: begin
        if (all_paused) begin
          nxt_st.chg = st_ff.chg & ~st_ff.acted;
          nxt_st.acted = '0;
          nxt_st.align = '0;
          nxt_st.cst = pcd_pkg::PCD_IDLE;
        end
      end
      default: begin
        nxt_st.cst = pcd_pkg::PCD_IDLE;
      end
    endcase
    // a ratio write landing in the clearing cycle keeps its flag
    for (int i = 0; i < pcd_pkg::NUM_DIV; i++) begin
      if (div_wr[i]) begin
        if (st_ff.pend[i] != div_wratio) begin
          nxt_st.chg[i] = 1'b1;
        end
        nxt_st.pend[i] = div_wratio;
        nxt_st.en[i] = div_wen;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '{mode: pcd_pkg::CTRL_MODE_RST, lrst: pcd_pkg::CTRL_LRST_RST,
                 src: pcd_pkg::CTRL_SRC_RST,
                 pend: {pcd_pkg::NUM_DIV{pcd_pkg::RATIO_RST}},
                 en: {pcd_pkg::NUM_DIV{pcd_pkg::DIV_EN_RST}},
                 chg: 16'h0000, acted: 16'h0000, align: 16'h0000,
                 cst: pcd_pkg::PCD_IDLE, acc: 7'h00, lock_cnt: 8'h00,
                 locked: 1'b0, tick: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // system dividers
  // ----------------------------------------
  for (genvar g = 0; g < pcd_pkg::NUM_DIV; g++) begin : g_div
    pcd_divider u_div (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .tick(eff_loop ? st_ff.tick : 1'b1),
      .enable(st_ff.en[g]),
      .new_ratio(st_ff.pend[g]),
      .load(load[g]),
      .pause(pause[g]),
      .restart(restart[g]),
      .clk_out(system_clock_out[g]),
      .paused(paused[g])
    );
  end

  always_comb begin
    loop_control_reg = '0;
    loop_control_reg[pcd_pkg::CTRL_MODE_BIT] = st_ff.mode;
    loop_control_reg[pcd_pkg::CTRL_LRST_BIT] = st_ff.lrst;
    loop_control_reg[pcd_pkg::CTRL_SRC_BIT] = st_ff.src;
    loop_control_reg[pcd_pkg::CTRL_ONE_BIT] = 1'b1;
  end

  assign commit_in_progress = (st_ff.cst == pcd_pkg::PCD_PAUSE);
  assign ratio_change_status = st_ff.chg;
  assign system_divider_enable = st_ff.en;
  assign loop_locked = st_ff.locked;
  assign loop_mode_active = eff_loop;
endmodule // pcd_controller

// ### sim/pcd_controller_asserts.sv
`timescale 1ns/1ps
module pcd_controller_chk (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  input wire logic [7:0] loop_control_reg,
  input wire logic [15:0] div_wr,
  input wire logic div_wen,
  input wire logic commit_set,
  input wire logic commit_in_progress,
  input wire logic [15:0] ratio_change_status,
  input wire logic [15:0] system_divider_enable,
  input wire logic loop_locked,
  input wire logic loop_mode_active,
  input wire logic [15:0] system_clock_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  chk_mode_source: assert property (loop_mode_active == (!loop_control_reg[5] && loop_control_reg[0]))
    else $error("mode active disagrees with source and mode bits");
  chk_ctrl_write: assert property (ctrl_wr |=> loop_control_reg == {2'h1, $past(ctrl_wdata[5]), 1'h0,
    $past(ctrl_wdata[3]), 2'h0, $past(ctrl_wdata[0])}) else $error("control readback wrong");
  chk_commit_start: assert property (commit_set && !commit_in_progress |=> commit_in_progress)
    else $error("commit did not start");
  chk_commit_bound: assert property ($rose(commit_in_progress) |-> ##[1:40] !commit_in_progress)
    else $error("commit never finished");
  chk_flag_source: assert property
    (((ratio_change_status & ~$past(ratio_change_status)) & ~$past(div_wr)) == 16'h0000)
    else $error("change flag set without a write");
  chk_disabled_quiet: assert property
    ((~system_divider_enable & ~$past(system_divider_enable) & system_clock_out) == 16'h0000)
    else $error("disabled divider toggles");
  chk_enable_write: assert property (|div_wr |=>
    ((system_divider_enable ^ {16{$past(div_wen)}}) & $past(div_wr)) == 16'h0000)
    else $error("divider enable not taken");
  chk_lock_reset: assert property (loop_control_reg[3] && $past(loop_control_reg[3]) |-> !loop_locked)
    else $error("locked while loop held in reset");
endmodule // pcd_controller_chk
bind pcd_controller pcd_controller_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .ctrl_wr(ctrl_wr),
  .ctrl_wdata(ctrl_wdata), .loop_control_reg(loop_control_reg), .div_wr(div_wr),
  .div_wen(div_wen), .commit_set(commit_set), .commit_in_progress(commit_in_progress),
  .ratio_change_status(ratio_change_status), .system_divider_enable(system_divider_enable),
  .loop_locked(loop_locked), .loop_mode_active(loop_mode_active),
  .system_clock_out(system_clock_out));

// ### sim/pcd_controller_tb.sv
`timescale 1ns/1ps
module pcd_controller_tb;
  logic sys_clk = 0, rst_n = 0, wr = 0, cset = 0, wen = 1, busy, lck, mact;
  logic [7:0] wd = 8'h00, ctl;
  logic [15:0] dwr = 16'h0000, aln = 16'h0000, flg, den, sck;
  logic [4:0] rat = 5'h00;
  int n_mismatch = 0, samples_checked = 0, cyc = 0, p, k;
  always #25 sys_clk = ~sys_clk;
  // multiplier and pre-divider tied at x1 and /1, so loop ticks match the reference
  pcd_controller dut (.sys_clk(sys_clk), .rst_n(rst_n), .ctrl_wr(wr), .ctrl_wdata(wd),
    .loop_control_reg(ctl), .multiplier_setting(6'h00), .reference_predivider(5'h00),
    .predivider_enable(1'b1), .div_wr(dwr), .div_wratio(rat), .div_wen(wen),
    .clock_align_control(aln), .commit_set(cset), .commit_in_progress(busy),
    .ratio_change_status(flg), .system_divider_enable(den), .loop_locked(lck),
    .loop_mode_active(mact), .system_clock_out(sck));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task conclude;
    if (n_mismatch == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task tick(input int n = 1);
    repeat (n) @(negedge sys_clk);
  endtask
  task wctl(input logic [7:0] d);
    wr = 1;
    wd = d;
    tick;
    wr = 0;
    tick;
  endtask
  task wdiv(input int i, input logic [4:0] r, input logic e);
    dwr = 16'h0001 << i;
    rat = r;
    wen = e;
    tick;
    dwr = 16'h0000;
    tick;
  endtask
  // cycles between two rising edges of one output, 0 if fewer than two seen within 99 cycles
  task period(input int i);
    int r0;
    logic pv;
    r0 = -1;
    p = 0;
    k = 0;
    pv = sck[i];
    while (k < 99 && p == 0) begin
      tick;
      k++;
      if (pv === 1'b0 && sck[i] === 1'b1) begin
        if (r0 < 0) r0 = k;
        else p = k - r0;
      end
      pv = sck[i];
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset;
    check(ctl, 16'h0068);
    check(mact, 16'h0000);
    check(den, 16'hffff);
    period(0);
    check(p, 16'h0002);
  endtask
  task t_mode;
    wctl(8'h29);
    check(mact, 16'h0000);
    wctl(8'h09);
    check(mact, 16'h0001);
    wctl(8'h08);
    check(mact, 16'h0000);
    tick(4);
    wctl(8'h08);
    tick(4);
    wctl(8'h00);
    check(ctl, 16'h0040);
    check(lck, 16'h0000);
    tick(pcd_pkg::LOCK_CYCLES - 1);
    check(lck, 16'h0000);
    tick(2);
    check(lck, 16'h0001);
    wctl(8'h01);
    check(ctl, 16'h0041);
    check(mact, 16'h0001);
    period(1);
    check(p, 16'h0002);
    wctl(8'h00);
    tick(4);
    wctl(8'h08);
    tick;
    check(lck, 16'h0000);
  endtask
  task t_commit;
    check(busy, 16'h0000);
    wdiv(2, 5'h03, 1'b1);
    check(flg, 16'h0004);
    wdiv(3, 5'h00, 1'b1);
    check(flg, 16'h0004);
    period(2);
    check(p, 16'h0002);
    wdiv(4, 5'h01, 1'b1);
    wdiv(5, 5'h02, 1'b1);
    aln = 16'h0014;
    cset = 1;
    tick;
    cset = 0;
    check(busy, 16'h0001);
    k = 0;
    while (busy === 1'b1 && k < 40) begin
      tick;
      k++;
    end
    check(k > 34, 16'h0000);
    check(sck & 16'h0014, 16'h0014);
    check(flg, 16'h0000);
    period(2);
    check(p, 16'h0008);
    period(4);
    check(p, 16'h0004);
    period(5);
    check(p, 16'h0006);
  endtask
  task t_disable;
    wdiv(7, 5'h00, 1'b0);
    check(den, 16'hff7f);
    tick;
    repeat (8) begin
      tick;
      check(sck[7], 16'h0000);
    end
    wdiv(7, 5'h00, 1'b1);
    period(7);
    check(p, 16'h0002);
  endtask
  initial begin
    tick(16);
    rst_n = 1;
    tick;
    t_reset;
    t_mode;
    t_commit;
    t_disable;
    conclude;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      conclude;
    end
  end
endmodule // pcd_controller_tb
